// ---- design/dioc_regs.svh ----
// Register offsets, field positions, reset values and codes for the pin bank.
`ifndef DIOC_REGS_SVH
`define DIOC_REGS_SVH

`define DIOC_NPINS        32
`define DIOC_IDX_W        5
`define DIOC_ADDR_W       8
`define DIOC_DATA_W       32

// Per-pin configuration word: address = pin index.
`define DIOC_PIN_BASE     8'h00
// Pin level readback at once for all pins in neither UART nor PWM use; others read 0.
`define DIOC_LEVEL_ADDR   8'h20
// Two PWM generators: half-period in cycles, then control state.
`define DIOC_PWM0_PER     8'h24
`define DIOC_PWM0_CTL     8'h28
`define DIOC_PWM1_PER     8'h2C
`define DIOC_PWM1_CTL     8'h30

// Fields of the per-pin word.
`define DIOC_F_FUNC       0
`define DIOC_F_DIR        1
`define DIOC_F_TYPE_LO    2
`define DIOC_F_TYPE_HI    3
`define DIOC_F_LEVEL      4
`define DIOC_F_SRC_LO     5
`define DIOC_F_SRC_HI     6
`define DIOC_F_STAT       7
`define DIOC_CFG_W        7

// Control field of a PWM control register.
`define DIOC_CTL_LO       0
`define DIOC_CTL_HI       2
`define DIOC_PER_W        16
`define DIOC_PER_RST      16'h0001
`define DIOC_ZERO32       32'h0000_0000

// Driver type codes.
`define DIOC_TYPE_PP      2'h0
`define DIOC_TYPE_OD      2'h1
`define DIOC_TYPE_TRI     2'h2

// Output source codes.
`define DIOC_SRC_NONE     2'h0
`define DIOC_SRC_PWM0     2'h1
`define DIOC_SRC_PWM1     2'h2

// PWM control codes.
`define DIOC_PWM_IDLE     3'h0
`define DIOC_PWM_STPLO    3'h1
`define DIOC_PWM_ONESHOT  3'h2
`define DIOC_PWM_RUN      3'h3
`define DIOC_PWM_STPHI    3'h4

`endif

// ---- design/dioc_pkg.sv ----
// Types shared by the pin bank design files.
package dioc_pkg;
   typedef enum logic [2:0] {
      DIOC_IDLE,
      DIOC_STPLO,
      DIOC_ONESHOT,
      DIOC_RUN,
      DIOC_STPHI
   } dioc_pwm_e;

   typedef struct packed {
      logic [1:0] src;
      logic       level;
      logic [1:0] drv;
      logic       dir;
      logic       gpio;
   } dioc_cfg_s;
endpackage

// ---- design/dioc_pwm.sv ----
// One PWM generator with idle, stop, run and one-shot control.
`timescale 1ns/1ps
`include "dioc_regs.svh"
module dioc_pwm (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [`DIOC_PER_W-1:0]  period,
   input  wire logic                    ctl_wr,
   input  wire dioc_pkg::dioc_pwm_e     ctl_in,
   output      dioc_pkg::dioc_pwm_e     ctl_out,
   output      logic                    pwm_out
);
   dioc_pkg::dioc_pwm_e       ctl_reg;
   dioc_pkg::dioc_pwm_e       ctl_next;
   logic [`DIOC_PER_W-1:0]    cnt_reg;
   logic [`DIOC_PER_W-1:0]    cnt_next;
   logic                      out_reg;
   logic                      out_next;
   logic                      shot_reg;
   logic                      shot_next;
   logic                      tick;

   assign tick    = (cnt_reg >= period - `DIOC_PER_W'(1));
   assign ctl_out = ctl_reg;
   assign pwm_out = out_reg;

   always_comb begin
      ctl_next  = ctl_reg;
      out_next  = out_reg;
      shot_next = shot_reg;
      cnt_next  = tick ? '0 : cnt_reg + `DIOC_PER_W'(1);
      if (ctl_wr) begin
         ctl_next  = ctl_in;
         cnt_next  = '0;
         shot_next = 1'b0;
         if (ctl_in == dioc_pkg::DIOC_ONESHOT) begin
            out_next = ~out_reg;
         end
      end else begin
         unique case (ctl_reg)
            dioc_pkg::DIOC_IDLE: begin
               cnt_next = '0;
            end
            dioc_pkg::DIOC_STPLO: begin
               out_next = 1'b0;
               cnt_next = '0;
            end
            dioc_pkg::DIOC_STPHI: begin
               out_next = 1'b1;
               cnt_next = '0;
            end
            dioc_pkg::DIOC_RUN: begin
               if (tick) begin
                  out_next = ~out_reg;
               end
            end
            dioc_pkg::DIOC_ONESHOT: begin
               // The opposite level lasts one half-period, then back.
               if (tick && !shot_reg) begin
                  out_next  = ~out_reg;
                  shot_next = 1'b1;
               end
               if (shot_reg) begin
                  ctl_next  = dioc_pkg::DIOC_IDLE;
                  shot_next = 1'b0;
               end
            end
            default: begin
               ctl_next = dioc_pkg::DIOC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_reg  <= dioc_pkg::DIOC_IDLE;
         cnt_reg  <= '0;
         out_reg  <= 1'b0;
         shot_reg <= 1'b0;
      end else begin
         ctl_reg  <= ctl_next;
         cnt_reg  <= cnt_next;
         out_reg  <= out_next;
         shot_reg <= shot_next;
      end
   end
endmodule

// ---- design/dioc_top.sv ----
// Configuration, drive and readback logic for a bank of dedicated I/O pins.
// How it works
// - A per-pin function bit hands the pin to GPIO when set, else to UART.
// - A per-pin direction bit makes the pin an output at 1, input at 0.
// - An output pin drives push-pull, open-drain or tri-state.
// - A per-pin level bit sets the driven level high or low.
// - Pins are numbered from zero and each setting is chosen by index.
// - A pin in neither UART nor PWM use reports its level as 1 or 0.
// - PWM runs idle, stop-low, stop-high, run or one-shot control.
// - Each pin takes its output from PWM 0, PWM 1 or neither.
`timescale 1ns/1ps
`include "dioc_regs.svh"
module dioc_top (
   input  wire logic                      CORE_CLK,
   input  wire logic                      RESET,
   input  wire logic [`DIOC_ADDR_W-1:0]   ADDR,
   input  wire logic [`DIOC_DATA_W-1:0]   WDATA,
   input  wire logic                      WR,
   input  wire logic                      RD,
   output      logic [`DIOC_DATA_W-1:0]   RDATA,
   input  wire logic [`DIOC_NPINS-1:0]    PIN_IN,
   output      logic [`DIOC_NPINS-1:0]    PIN_OUT,
   output      logic [`DIOC_NPINS-1:0]    PIN_OE_N,
   output      logic [`DIOC_NPINS-1:0]    GPIO_OWN,
   input  wire logic [`DIOC_NPINS-1:0]    UART_OUT,
   input  wire logic [`DIOC_NPINS-1:0]    UART_OE
);
   dioc_pkg::dioc_cfg_s       cfg_reg [`DIOC_NPINS];
   logic [`DIOC_NPINS-1:0]    sync1_reg;
   logic [`DIOC_NPINS-1:0]    sync2_reg;
   logic [`DIOC_PER_W-1:0]    per0_reg;
   logic [`DIOC_PER_W-1:0]    per1_reg;
   logic [`DIOC_DATA_W-1:0]   rdata_next;
   logic [`DIOC_NPINS-1:0]    out_next;
   logic [`DIOC_NPINS-1:0]    oe_n_next;
   logic [`DIOC_NPINS-1:0]    own_next;
   logic [`DIOC_NPINS-1:0]    status_bits;
   dioc_pkg::dioc_pwm_e       ctl0;
   dioc_pkg::dioc_pwm_e       ctl1;
   logic                      pwm0;
   logic                      pwm1;
   logic                      pin_hit;
   logic [`DIOC_IDX_W-1:0]    pin_idx;
   logic                      wr_ctl0;
   logic                      wr_ctl1;
   dioc_pkg::dioc_pwm_e       wctl;

   assign pin_hit = (ADDR < 8'(`DIOC_NPINS));
   assign pin_idx = ADDR[`DIOC_IDX_W-1:0];
   assign wr_ctl0 = WR && (ADDR == `DIOC_PWM0_CTL);
   assign wr_ctl1 = WR && (ADDR == `DIOC_PWM1_CTL);
   assign wctl    = dioc_pkg::dioc_pwm_e'(WDATA[`DIOC_CTL_HI:`DIOC_CTL_LO]);

   dioc_pwm u_pwm0 (
      .clk     (CORE_CLK),
      .rst     (RESET),
      .period  (per0_reg),
      .ctl_wr  (wr_ctl0),
      .ctl_in  (wctl),
      .ctl_out (ctl0),
      .pwm_out (pwm0)
   );

   dioc_pwm u_pwm1 (
      .clk     (CORE_CLK),
      .rst     (RESET),
      .period  (per1_reg),
      .ctl_wr  (wr_ctl1),
      .ctl_in  (wctl),
      .ctl_out (ctl1),
      .pwm_out (pwm1)
   );

   // Pin levels come from outside, so they pass two flip-flops first.
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= PIN_IN;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         for (int i = 0; i < `DIOC_NPINS; i++) begin
            cfg_reg[i] <= '0;
         end
         per0_reg <= `DIOC_PER_RST;
         per1_reg <= `DIOC_PER_RST;
      end else if (WR) begin
         if (pin_hit) begin
            cfg_reg[pin_idx] <= dioc_pkg::dioc_cfg_s'(
               WDATA[`DIOC_CFG_W-1:0]);
         end
         if (ADDR == `DIOC_PWM0_PER) begin
            per0_reg <= WDATA[`DIOC_PER_W-1:0];
         end
         if (ADDR == `DIOC_PWM1_PER) begin
            per1_reg <= WDATA[`DIOC_PER_W-1:0];
         end
      end
   end

   // Per-pin drive decision; a generate loop keeps each pin identical.
   for (genvar p = 0; p < `DIOC_NPINS; p++) begin : g_pin
      logic lvl;
      logic pwm_used;
      assign pwm_used = (cfg_reg[p].src == `DIOC_SRC_PWM0) ||
                        (cfg_reg[p].src == `DIOC_SRC_PWM1);
      assign lvl = (cfg_reg[p].src == `DIOC_SRC_PWM0) ? pwm0 :
                   (cfg_reg[p].src == `DIOC_SRC_PWM1) ? pwm1 :
                   cfg_reg[p].level; // output level
      always_comb begin
         own_next[p]  = cfg_reg[p].gpio;
         out_next[p]  = 1'b0;
         oe_n_next[p] = 1'b1;
         if (!cfg_reg[p].gpio) begin
            out_next[p]  = UART_OUT[p];
            oe_n_next[p] = ~UART_OE[p];
         end else if (cfg_reg[p].dir) begin
            unique case (cfg_reg[p].drv)
               `DIOC_TYPE_PP: begin
                  out_next[p]  = lvl;
                  oe_n_next[p] = 1'b0;
               end
               `DIOC_TYPE_OD: begin
                  out_next[p]  = 1'b0;
                  oe_n_next[p] = lvl;
               end
               default: begin
                  // Tri-state and the unused code leave the pin floating.
                  out_next[p]  = lvl;
                  oe_n_next[p] = 1'b1;
               end
            endcase
         end
      end
      assign status_bits[p] = cfg_reg[p].gpio && !pwm_used && sync2_reg[p];
   end

   // Read mux; the answer stands one cycle after the strobe.
   always_comb begin
      rdata_next = `DIOC_ZERO32;
      if (RD) begin
         if (pin_hit) begin
            rdata_next[`DIOC_CFG_W-1:0] = cfg_reg[pin_idx];
            rdata_next[`DIOC_F_STAT]    = status_bits[pin_idx];
         end else if (ADDR == `DIOC_LEVEL_ADDR) begin
            rdata_next = status_bits;
         end else if (ADDR == `DIOC_PWM0_PER) begin
            rdata_next[`DIOC_PER_W-1:0] = per0_reg;
         end else if (ADDR == `DIOC_PWM1_PER) begin
            rdata_next[`DIOC_PER_W-1:0] = per1_reg;
         end else if (ADDR == `DIOC_PWM0_CTL) begin
            rdata_next[`DIOC_CTL_HI:`DIOC_CTL_LO] = ctl0;
         end else if (ADDR == `DIOC_PWM1_CTL) begin
            rdata_next[`DIOC_CTL_HI:`DIOC_CTL_LO] = ctl1;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         RDATA    <= `DIOC_ZERO32;
         PIN_OUT  <= '0;
         PIN_OE_N <= '1;
         GPIO_OWN <= '0;
      end else begin
         RDATA    <= rdata_next;
         PIN_OUT  <= out_next;
         PIN_OE_N <= oe_n_next;
         GPIO_OWN <= own_next;
      end
   end
endmodule

// ---- dv/dioc_ext.sv ----
// Outside circuits on the pins: a pull-up and an optional driver.
`timescale 1ns/1ps
module dioc_ext (
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe_n,
   input  wire logic [31:0] ext_en,
   input  wire logic [31:0] ext_val,
   output      logic [31:0] pin_in
);
   // A released pin with no outside driver rests at the pull-up level.
   assign pin_in = ~pin_oe_n & pin_out | pin_oe_n & ext_en & ext_val
                 | pin_oe_n & ~ext_en;
endmodule

// ---- dv/dioc_top_properties.sv ----
// Concurrent checks on the pin bank ports.
`timescale 1ns/1ps
module dioc_top_properties (
   input wire logic        CORE_CLK,
   input wire logic        RESET,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   input wire logic [31:0] PIN_OUT,
   input wire logic [31:0] PIN_OE_N,
   input wire logic [31:0] GPIO_OWN,
   input wire logic [31:0] UART_OUT,
   input wire logic [31:0] UART_OE
);
   logic [7:0]  a1, a2;
   logic [31:0] w1, w2;
   logic        p1, p2;
   logic        wp;
   logic [4:0]  i2;
   assign wp = WR && ADDR < 8'h20;
   assign i2 = a2[4:0];
   // Delay lines let a check two cycles on see the write that caused it.
   always_ff @(posedge CORE_CLK) begin
      {a2, a1} <= {a1, ADDR};
      {w2, w1} <= {w1, WDATA};
      {p2, p1} <= {p1, wp};
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   rd_idle_a: assert property (!$past(RD) |-> RDATA == '0)
      else $error("read data not zero outside a read");
   own_set_a: assert property (wp |-> ##2 GPIO_OWN[i2] == w2[0])
      else $error("pin owner does not follow its function bit");
   pp_drive_a: assert property (wp && WDATA[6:0] ==? 7'b00x0011
      |-> ##2 !PIN_OE_N[i2] && PIN_OUT[i2] == w2[4])
      else $error("push-pull pin not driving its level");
   od_drive_a: assert property (wp && WDATA[6:0] ==? 7'b00x0111
      |-> ##2 PIN_OE_N[i2] == w2[4] && !PIN_OUT[i2])
      else $error("open-drain pin drives high");
   tri_drive_a: assert property (wp && WDATA[6:0] ==? 7'b00x1011
      |-> ##2 PIN_OE_N[i2])
      else $error("tri-state pin is driving");
   in_drive_a: assert property (wp && WDATA[6:0] ==? 7'b00xxx01
      |-> ##2 PIN_OE_N[i2] && !PIN_OUT[i2])
      else $error("input pin is driving");
   uart_pass_a: assert property (!$past(RESET) |->
      ((PIN_OUT ^ $past(UART_OUT) | PIN_OE_N ^ ~$past(UART_OE))
      & ~GPIO_OWN & ~$past(GPIO_OWN)) == '0)
      else $error("serial pin does not carry the serial drive");
   own_hold_a: assert property (!p2 && !$past(RESET)
      |-> $stable(GPIO_OWN))
      else $error("pin owner changed without a write");
   cover property (WR && ADDR == 8'h28);
   cover property (RD && ADDR == 8'h20);
   cover property (wp && WDATA[0]);
endmodule
bind dioc_top dioc_top_properties chk (.CORE_CLK, .RESET, .ADDR, .WDATA,
   .WR, .RD, .RDATA, .PIN_OUT, .PIN_OE_N, .GPIO_OWN, .UART_OUT, .UART_OE);

// ---- dv/dioc_top_tb.sv ----
// Self-checking bench for the pin bank.
`timescale 1ns/1ps
module dioc_top_tb;
   logic        clk, rst, wr, rd;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, pin_in, pin_out, oe_n, own;
   logic [31:0] u_out, u_oe, ext_en, ext_val, v;
   int          miscompares, n_checks, cyc, cnt;
   localparam logic [7:0] CFG [5] = '{8'h13, 8'h17, 8'h07, 8'h0B, 8'h01};
   localparam logic [4:0] EO = 5'h01;
   localparam logic [4:0] EE = 5'h1A;
   dioc_top dut (.CORE_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .PIN_OE_N(oe_n), .GPIO_OWN(own), .UART_OUT(u_out), .UART_OE(u_oe));
   dioc_ext ext (.pin_out(pin_out), .pin_oe_n(oe_n), .ext_en(ext_en),
      .ext_val(ext_val), .pin_in(pin_in));
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic hi(input int n);
      cnt = 0;
      repeat (n) begin
         tk(1);
         cnt += int'(pin_out[5]);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         miscompares++;
         finish_test;
      end
   end
   initial begin
      rst = 1;
      wr = 0;
      rd = 0;
      addr = 0;
      wdata = 0;
      u_out = 32'h0000_A5A5;
      u_oe = 32'h0000_00FF;
      ext_en = 32'h0000_0008;
      ext_val = 0;
      repeat (3) @(posedge clk);
      rst <= 0;
      tk(3);
      chk("owner", own, 0);
      chk("serial out", pin_out, u_out);
      chk("serial oe", oe_n, ~u_oe);
      for (int p = 0; p < 32; p += 31) begin
         for (int k = 0; k < 5; k++) begin
            bus_wr(8'(p), {24'h0, CFG[k]});
            tk(2);
            if (k != 3) chk("out", 32'(pin_out[p]), 32'(EO[k]));
            chk("oe", 32'(oe_n[p]), 32'(EE[k]));
            chk("index", 32'(own[p]), 1);
         end
      end
      bus_wr(8'h03, 32'h0000_0001);
      for (int b = 0; b < 2; b++) begin
         ext_val <= 32'(b) << 3;
         tk(4);
         bus_rd(8'h20);
         chk("level", 32'(v[3]), 32'(b));
      end
      chk("serial level", 32'(v[4]), 0);
      bus_rd(8'h03);
      chk("pin status", v, 32'h0000_0081);
      bus_wr(8'h24, 32'h0000_0004);
      bus_wr(8'h05, 32'h0000_0023);
      bus_wr(8'h06, 32'h0000_0043);
      bus_wr(8'h30, 32'h0000_0004);
      bus_wr(8'h28, 32'h0000_0004);
      tk(3);
      chk("stop high", 32'(pin_out[5]), 1);
      chk("second gen", 32'(pin_out[6]), 1);
      bus_rd(8'h05);
      chk("cfg read", v, 32'h0000_0023);
      bus_rd(8'h24);
      chk("period read", v, 32'h0000_0004);
      bus_rd(8'h30);
      chk("ctl1 read", v, 32'h0000_0004);
      bus_rd(8'h20);
      chk("pwm level", 32'(v[5]), 0);
      bus_wr(8'h28, 32'h0000_0001);
      tk(3);
      chk("stop low", 32'(pin_out[5]), 0);
      bus_wr(8'h28, 32'h0000_0002);
      hi(20);
      chk("one shot", cnt, 4);
      bus_rd(8'h28);
      chk("ctl idle", v, 0);
      bus_wr(8'h28, 32'h0000_0003);
      tk(4);
      hi(32);
      chk("run", cnt, 16);
      bus_wr(8'h05, 32'h0000_0003);
      tk(2);
      chk("no gen", 32'(pin_out[5]), 0);
      bus_wr(8'h00, 32'h0000_0000);
      tk(2);
      chk("back serial", 32'(oe_n[0]), 0);
      @(posedge clk);
      u_out <= 32'h0000_5A5A;
      u_oe <= 32'h0000_0F0F;
      tk(2);
      chk("serial follow", pin_out & ~own, 32'h0000_5A12);
      chk("serial follow oe", oe_n & ~own, 32'h7FFF_F090);
      bus_rd(8'hF0);
      chk("unmapped", v, 0);
      bus_wr(8'hF0, 32'hFFFF_FFFF);
      tk(3);
      chk("hold", own, 32'h8000_0068);
      finish_test;
   end
endmodule
